/* verilog/usart_rx_pkg.sv */
// package: constants, modes and layouts for the serial receive/transfer block
//
// How it works
// - error flags ride with frame; low read pops
// - nine-bit low-first: high read pops instead
// - receiver disable flushes buffer, drops partial frame
// - clock pin direction picks master or slave
// - sample on edge opposite transmit edge
// - invert zero: rise starts bit, fall samples
// - slave speed set only by external clock
// - spi frame is exactly eight data bits
// - data order bit picks lsb or msb first
// - spi clock comes from baud generator
// - spi bit held one period, sampled mid
// - invert and phase select sample/transmit edges
// - spi mode error flags always read zero
// - spi flags behave as general operation
// - no collision, double speed, multimaster, select
// - tx is mosi, rx is miso, clock sck
// - four async modes, one double speed
// - mode 0x00 sixteen samples, 0x01 eight
// - clock recovery aligns frame to baud tick
// - start bit: two of three middle samples low
// - data bits by three-sample majority vote
// - only first stop checked, low sets frame error
package usart_rx_pkg;
	// communication modes
	typedef enum logic [1:0] {
		MODE_ASYNC = 2'b00,
		MODE_SYNC = 2'b01,
		MODE_SPI_MASTER = 2'b11
	} comm_mode_type;
	// character sizes, nine bit low first has its own code
	localparam logic [2:0] CHSZ_5 = 3'h0;
	localparam logic [2:0] CHSZ_8 = 3'h3;
	localparam logic [2:0] CHSZ_9_LOW_FIRST = 3'h6;
	localparam logic [2:0] CHSZ_9_HIGH_FIRST = 3'h7;
	// receive sampling modes
	localparam logic [1:0] RXM_NORMAL = 2'h0;
	localparam logic [1:0] RXM_DOUBLE = 2'h1;
	localparam logic [1:0] RXM_GENAUTO = 2'h2;
	localparam logic [1:0] RXM_LINAUTO = 2'h3;
	localparam int SAMPLES_NORMAL = 16;
	localparam int SAMPLES_DOUBLE = 8;
	// high data register field layout
	localparam int HI_DATA8_POS = 0;
	localparam int HI_PARITY_ERROR_FLAG_POS = 1;
	localparam int HI_FRAME_ERROR_FLAG_POS = 2;
	localparam int HI_OVF_POS = 6;
	localparam int HI_RXC_POS = 7;
	localparam int SPI_BITS = 8;
	localparam logic [15:0] BAUD_RESET = 16'h0040;
	localparam int FIFO_DEPTH = 2;
	// buffer entry: 9 data bits plus frame and parity errors
	typedef struct packed {
		logic frame_error_flag;
		logic parity_error_flag;
		logic [8:0] data;
	} rx_word_type;
endpackage : usart_rx_pkg

/* verilog/rx_word_if.sv */
// interface: word stream between shifter and receive buffer
`timescale 1ns/1ps
interface rx_word_if;
	import usart_rx_pkg::*;
	logic valid;
	logic ready;
	rx_word_type word;
	modport src (output valid, output word, input ready);
	modport dst (input valid, input word, output ready);
endinterface : rx_word_if

/* verilog/rx_fifo.sv */
// two-entry receive buffer with valid/ready on both sides
`timescale 1ns/1ps
module rx_fifo #(
	parameter int DEPTH = usart_rx_pkg::FIFO_DEPTH
) (
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic ce_in,
	input wire logic flush_in,
	rx_word_if.dst wr,
	output logic rd_valid_out,
	input wire logic rd_ready_in,
	output usart_rx_pkg::rx_word_type rd_word_out,
	output logic ovf_out
);
	import usart_rx_pkg::*;
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	// refused at elaboration: one entry cannot ride out a reader stall
	if (DEPTH < 2) begin : g_depth_check
		$error("rx_fifo needs depth of two or more");
	end
	rx_word_type mem_r [DEPTH];
	rx_word_type mem_nxt [DEPTH];
	logic [AW-1:0] rd_r, rd_nxt, wr_r, wr_nxt;
	logic [AW:0] cnt_r, cnt_nxt;
	logic ovf_r, ovf_nxt;
	logic push, pop;

	// pointer wrap shared by both ends
	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction : bump

	assign wr.ready = (cnt_r != (AW+1)'(DEPTH));
	assign rd_valid_out = (cnt_r != '0);
	assign rd_word_out = mem_r[rd_r];
	assign ovf_out = ovf_r;
	assign push = wr.valid && wr.ready;
	assign pop = rd_valid_out && rd_ready_in;

	// next state; flush empties at once and clears overflow
	always_comb begin
		mem_nxt = mem_r;
		rd_nxt = rd_r;
		wr_nxt = wr_r;
		cnt_nxt = cnt_r;
		ovf_nxt = ovf_r;
		if (flush_in) begin
			rd_nxt = '0;
			wr_nxt = '0;
			cnt_nxt = '0;
			ovf_nxt = 1'b0;
		end else begin
			if (push) begin
				mem_nxt[wr_r] = wr.word;
				wr_nxt = bump(wr_r);
			end
			if (pop) begin
				rd_nxt = bump(rd_r);
			end
			// set wins over the clear a pop gives
			if (wr.valid && !wr.ready) begin
				ovf_nxt = 1'b1;
			end else if (pop) begin
				ovf_nxt = 1'b0;
			end
			cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			for (int i = 0; i < DEPTH; i++) mem_r[i] <= '0;
			rd_r <= '0;
			wr_r <= '0;
			cnt_r <= '0;
			ovf_r <= 1'b0;
		end else if (ce_in) begin
			mem_r <= mem_nxt;
			rd_r <= rd_nxt;
			wr_r <= wr_nxt;
			cnt_r <= cnt_nxt;
			ovf_r <= ovf_nxt;
		end
	end
endmodule : rx_fifo

/* verilog/usart_rx_core.sv */
// receiver core: async clock recovery, sync master/slave and spi master receive
`timescale 1ns/1ps
module usart_rx_core #(
	parameter int BAUD_W = 16
) (
	input wire logic mclk_in,
	input wire logic arst_n_in,
	input wire logic ce_in,
	input wire logic rx_enable_in,
	input usart_rx_pkg::comm_mode_type comm_mode_in,
	input wire logic [2:0] char_size_field_in,
	input wire logic [1:0] rx_sampling_mode_in,
	input wire logic [1:0] parity_mode_in,
	input wire logic data_order_bit_in,
	input wire logic clock_phase_bit_in,
	input wire logic pin_invert_enable_in,
	input wire logic transfer_clock_dir_in,
	input wire logic [BAUD_W-1:0] baud_in,
	input wire logic rxd_in,
	input wire logic transfer_clock_pin_in,
	output logic transfer_clock_pin_out,
	output logic transfer_clock_pin_oe_out,
	input wire logic rd_high_in,
	input wire logic rd_low_in,
	output logic [7:0] rx_data_low_reg_out,
	output logic [7:0] rx_data_high_reg_out,
	output logic rx_complete_flag_out
);
	import usart_rx_pkg::*;
	// the integer part needs bits above the six fraction bits
	if (BAUD_W < 7 || BAUD_W > 16) begin : g_baud_check
		$error("baud width must be 7..16");
	end

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_START = 2'b01,
		ST_DATA = 2'b10,
		ST_STOP = 2'b11
	} rx_state_type;

	rx_word_if wif ();
	logic fifo_valid, pop, ovf, flush;
	rx_word_type head;

	// majority of three samples
	function automatic logic vote(input logic [2:0] s);
		vote = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
	endfunction : vote

	// data bits per character; spi always eight
	function automatic logic [3:0] nbits(input logic [2:0] cs, input logic spi);
		if (spi) nbits = 4'(SPI_BITS);
		else if (cs >= CHSZ_9_LOW_FIRST) nbits = 4'h9;
		else if (cs > CHSZ_8) nbits = 4'h8;
		else nbits = 4'(cs - CHSZ_5) + 4'h5;
	endfunction : nbits

	wire spi = (comm_mode_in == MODE_SPI_MASTER);
	wire sync_m = (comm_mode_in != MODE_ASYNC);
	wire master = transfer_clock_dir_in;
	wire dbl = (rx_sampling_mode_in == RXM_DOUBLE);
	assign flush = !rx_enable_in;

	//////////////////////////////////////////////////////////////////////
	// baud generator: async tick at S per bit, sync half-period tick
	logic [15:0] bcnt_r, bcnt_nxt;
	logic [9:0] frac_r, frac_nxt;
	logic tick, xck_r, xck_nxt;
	logic busy_clk;
	always_comb begin
		bcnt_nxt = bcnt_r;
		frac_nxt = frac_r;
		tick = 1'b0;
		if (bcnt_r == 16'h0) begin
			tick = 1'b1;
			if (sync_m) begin
				// only the integer part counts in synchronous mode
				bcnt_nxt = 16'(baud_in[BAUD_W-1:6]) - 16'h1;
			end else begin
				// fractional adjust: extra cycle when the fraction carries
				frac_nxt = 10'(frac_r[5:0]) + 10'(baud_in[5:0]);
				bcnt_nxt = 16'(baud_in[BAUD_W-1:6]) - 16'h1 + 16'(frac_nxt[6]);
				frac_nxt = {4'h0, frac_nxt[5:0]};
			end
		end else begin
			bcnt_nxt = bcnt_r - 16'h1;
		end
		// master clock toggles every tick; idles at its rest level
		xck_nxt = xck_r;
		if (sync_m && master && busy_clk && tick) xck_nxt = !xck_r;
		else if (!busy_clk) xck_nxt = 1'b0;
	end
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			bcnt_r <= '0;
			frac_r <= '0;
			xck_r <= 1'b0;
		end else if (ce_in) begin
			bcnt_r <= bcnt_nxt;
			frac_r <= frac_nxt;
			xck_r <= xck_nxt;
		end
	end
	// pin inversion applied at the pin like the port does
	assign transfer_clock_pin_out = xck_r ^ pin_invert_enable_in;
	assign transfer_clock_pin_oe_out = sync_m && master;

	//////////////////////////////////////////////////////////////////////
	// slave clock synchroniser; baud ignored in slave mode
	logic s1_r, s2_r, s3_r;
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end else if (ce_in) begin
			s1_r <= transfer_clock_pin_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end
	// logical clock after inversion; edges need two samples per level
	logic tick_d, xck_nxt_prev;
	// remembers whether the master clock toggled on the last edge
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) tick_d <= 1'b0;
		else if (ce_in) tick_d <= tick && busy_clk && master;
	end
	assign xck_nxt_prev = !(xck_r ^ (sync_m && master && busy_clk && tick_d));
	wire lclk_now = master ? xck_r : (s2_r ^ pin_invert_enable_in);
	wire lclk_prev = master ? !xck_nxt_prev : (s3_r ^ pin_invert_enable_in);
	wire rise = lclk_now && !lclk_prev;
	wire fall = !lclk_now && lclk_prev;
	// sample edge: opposite the transmit edge spi phase picks it
	wire samp_edge = spi ? (clock_phase_bit_in ? fall : rise) : fall;

	//////////////////////////////////////////////////////////////////////
	// receive sequencer
	rx_state_type st_r, st_nxt;
	logic [3:0] sc_r, sc_nxt;
	logic [3:0] bi_r, bi_nxt;
	logic [2:0] sm_r, sm_nxt;
	logic [8:0] sh_r, sh_nxt;
	logic par_r, par_nxt;
	logic rxd_d_r, rxd_d_nxt;
	logic wv_r, wv_nxt;
	rx_word_type w_r, w_nxt;
	wire [3:0] nb = nbits(char_size_field_in, spi);
	wire [3:0] smid = dbl ? 4'(SAMPLES_DOUBLE / 2) : 4'(SAMPLES_NORMAL / 2);
	wire [3:0] slast = dbl ? 4'(SAMPLES_DOUBLE - 1) : 4'(SAMPLES_NORMAL - 1);
	wire use_par = !spi && !sync_m ? parity_mode_in[1] : (!spi && parity_mode_in[1]);
	assign busy_clk = sync_m && master && (st_r == ST_DATA || wv_r == 1'b0 && st_r != ST_IDLE);

	always_comb begin
		st_nxt = st_r;
		sc_nxt = sc_r;
		bi_nxt = bi_r;
		sm_nxt = sm_r;
		sh_nxt = sh_r;
		par_nxt = par_r;
		wv_nxt = wv_r && !wif.ready;
		w_nxt = w_r;
		// last sample per tick, so a slow baud still sees the start edge
		rxd_d_nxt = tick ? rxd_in : rxd_d_r;
		if (flush) begin
			// partial frame dropped immediately
			st_nxt = ST_IDLE;
			wv_nxt = 1'b0;
		end else if (sync_m) begin
			case (st_r)
				ST_IDLE: begin
					// master spi starts a frame whenever receiver idle
					if (spi || !rxd_in || !master) begin
						st_nxt = ST_DATA;
						bi_nxt = '0;
						par_nxt = 1'b0;
					end
				end
				ST_DATA: begin
					if (samp_edge) begin
						// lsb- or msb-first assembly
						if (spi && !data_order_bit_in) sh_nxt = {1'b0, sh_r[6:0], rxd_in};
						else sh_nxt = {rxd_in, sh_r[8:1]};
						bi_nxt = bi_r + 4'h1;
						if (bi_r == nb - 4'h1) st_nxt = ST_STOP;
					end
				end
				ST_STOP: begin
					// spi has no framing bits; errors forced zero
					w_nxt.data = spi && !data_order_bit_in ? sh_nxt : sh_r >> (4'h9 - nb);
					w_nxt.frame_error_flag = 1'b0;
					w_nxt.parity_error_flag = 1'b0;
					wv_nxt = 1'b1;
					st_nxt = ST_IDLE;
				end
				default: st_nxt = ST_IDLE;
			endcase
		end else if (tick) begin
			sc_nxt = sc_r + 4'h1;
			case (st_r)
				ST_IDLE: begin
					// falling edge from idle starts detection; sample 1 is first low
					sc_nxt = 4'h1;
					if (!rxd_in && rxd_d_r) st_nxt = ST_START;
				end
				ST_START: begin
					if (sc_r >= smid - 4'h1 && sc_r <= smid + 4'h1) sm_nxt = {sm_r[1:0], rxd_in};
					if (sc_r == smid + 4'h1) begin
						// accept when two or three samples low
						if (!vote({sm_r[1:0], rxd_in})) begin
							st_nxt = ST_DATA;
							bi_nxt = '0;
							par_nxt = 1'b0;
							sc_nxt = smid + 4'h2;
						end else begin
							st_nxt = ST_IDLE;
						end
					end
				end
				ST_DATA, ST_STOP: begin
					if (sc_r == slast) sc_nxt = '0;
					if (sc_r >= smid - 4'h1 && sc_r <= smid + 4'h1) sm_nxt = {sm_r[1:0], rxd_in};
					if (sc_r == smid + 4'h1) begin
						if (st_r == ST_DATA) begin
							// data/parity decided by centre vote
							if (bi_r < nb) begin
								sh_nxt = {vote({sm_r[1:0], rxd_in}), sh_r[8:1]};
								par_nxt = par_r ^ vote({sm_r[1:0], rxd_in});
							end else begin
								par_nxt = par_r ^ vote({sm_r[1:0], rxd_in})
									^ parity_mode_in[0];
							end
							bi_nxt = bi_r + 4'h1;
							if (bi_r == nb - 4'h1 + 4'(use_par)) st_nxt = ST_STOP;
						end else begin
							// only the first stop bit is checked
							w_nxt.data = sh_r >> (4'h9 - nb);
							w_nxt.frame_error_flag = !vote({sm_r[1:0], rxd_in});
							w_nxt.parity_error_flag = use_par && par_r;
							wv_nxt = 1'b1;
							st_nxt = ST_IDLE;
						end
					end
				end
				default: st_nxt = ST_IDLE;
			endcase
		end
	end
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			st_r <= ST_IDLE;
			sc_r <= '0;
			bi_r <= '0;
			sm_r <= '0;
			sh_r <= '0;
			par_r <= 1'b0;
			rxd_d_r <= 1'b1;
			wv_r <= 1'b0;
			w_r <= '0;
		end else if (ce_in) begin
			st_r <= st_nxt;
			sc_r <= sc_nxt;
			bi_r <= bi_nxt;
			sm_r <= sm_nxt;
			sh_r <= sh_nxt;
			par_r <= par_nxt;
			rxd_d_r <= rxd_d_nxt;
			wv_r <= wv_nxt;
			w_r <= w_nxt;
		end
	end
	assign wif.valid = wv_r;
	assign wif.word = w_r;

	//////////////////////////////////////////////////////////////////////
	// receive buffer; flags travel with their frame
	rx_fifo #(.DEPTH(FIFO_DEPTH)) u_fifo (
		.clk_in(mclk_in),
		.arst_n_in(arst_n_in),
		.ce_in(ce_in),
		.flush_in(flush),
		.wr(wif),
		.rd_valid_out(fifo_valid),
		.rd_ready_in(pop),
		.rd_word_out(head),
		.ovf_out(ovf)
	);
	// pop register: low normally, high in nine-bit low-first
	assign pop = (char_size_field_in == CHSZ_9_LOW_FIRST) ? rd_high_in : rd_low_in;
	// flushing by repeated reads until the flag clears works from this
	assign rx_complete_flag_out = fifo_valid;
	always_comb begin
		rx_data_low_reg_out = head.data[7:0];
		rx_data_high_reg_out = 8'h00;
		rx_data_high_reg_out[HI_DATA8_POS] = head.data[8];
		rx_data_high_reg_out[HI_PARITY_ERROR_FLAG_POS] = head.parity_error_flag && !spi;
		rx_data_high_reg_out[HI_FRAME_ERROR_FLAG_POS] = head.frame_error_flag && !spi;
		rx_data_high_reg_out[HI_OVF_POS] = ovf && !spi;
		rx_data_high_reg_out[HI_RXC_POS] = fifo_valid;
		if (!fifo_valid) rx_data_low_reg_out = 8'h00;
	end
	// no collision, select or multi-master logic exists here
endmodule : usart_rx_core

/* verif/usart_rx_assertions.sv */
// checker: port-level properties of the receive block
`timescale 1ns/1ps
module usart_rx_assertions (
	input wire logic mclk_in,
	input wire logic arst_n_in,
	input wire logic rx_enable_in,
	input usart_rx_pkg::comm_mode_type comm_mode_in,
	input wire logic [2:0] char_size_field_in,
	input wire logic transfer_clock_dir_in,
	input wire logic rd_high_in,
	input wire logic rd_low_in,
	input wire logic transfer_clock_pin_oe_out,
	input wire logic [7:0] rx_data_low_reg_out,
	input wire logic [7:0] rx_data_high_reg_out,
	input wire logic rx_complete_flag_out
);
	import usart_rx_pkg::*;
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!arst_n_in);
	wire logic nine_lo;
	// nine-bit low-first moves the popping read to the high register
	assign nine_lo = (char_size_field_in == CHSZ_9_LOW_FIRST);
	////////////////////////////////////////
	sequence s_no_read;
		rx_complete_flag_out && rx_enable_in && !rd_high_in && !rd_low_in;
	endsequence
	sequence s_peek;
		rx_complete_flag_out && rx_enable_in && !(rd_high_in && rd_low_in)
			&& (nine_lo ? rd_low_in : rd_high_in);
	endsequence
	a_head_holds: assert property (s_no_read |=> $stable(rx_data_low_reg_out))
		else $error("head word changed without a read");
	a_peek_no_pop: assert property (s_peek |=>
		$stable(rx_data_low_reg_out) && rx_complete_flag_out)
		else $error("non-popping read advanced the buffer");
	a_disable_flush: assert property (!rx_enable_in |=> !rx_complete_flag_out)
		else $error("buffer not flushed on receiver disable");
	a_rise_enabled: assert property ($rose(rx_complete_flag_out) |-> $past(rx_enable_in))
		else $error("word stored while receiver disabled");
	a_flag_in_high: assert property (rx_data_high_reg_out[HI_RXC_POS] == rx_complete_flag_out)
		else $error("complete bit differs from flag");
	a_empty_zero: assert property (!rx_complete_flag_out |-> rx_data_low_reg_out == 8'h00)
		else $error("low data not zero when empty");
	a_spi_err_zero: assert property ((comm_mode_in == MODE_SPI_MASTER) [*2] |->
		!rx_data_high_reg_out[HI_FRAME_ERROR_FLAG_POS] && !rx_data_high_reg_out[HI_PARITY_ERROR_FLAG_POS])
		else $error("error flag set in spi mode");
	a_master_oe: assert property ((comm_mode_in == MODE_SYNC && transfer_clock_dir_in) [*2]
		|-> transfer_clock_pin_oe_out)
		else $error("sync master not driving clock");
	a_slave_no_oe: assert property ((comm_mode_in == MODE_SYNC && !transfer_clock_dir_in) [*2]
		|-> !transfer_clock_pin_oe_out)
		else $error("sync slave driving clock");
endmodule : usart_rx_assertions
bind usart_rx_core usart_rx_assertions usart_rx_assertions_inst (.mclk_in, .arst_n_in,
	.rx_enable_in, .comm_mode_in, .char_size_field_in, .transfer_clock_dir_in, .rd_high_in,
	.rd_low_in, .transfer_clock_pin_oe_out, .rx_data_low_reg_out, .rx_data_high_reg_out,
	.rx_complete_flag_out);

/* verif/uart_peer_model.sv */
// partner model: remote serial peer sending asynchronous frames
`timescale 1ns/1ps
module uart_peer_model (
	input wire logic mclk_in,
	output logic rxd_out,
	output logic xclk_out
);
	// line idles high; slave clock stands still, never near the quarter-rate limit
	initial begin
		rxd_out = 1'b1;
		xclk_out = 1'b0;
	end
	////////////////////////////////////////
	task automatic hold_line(input logic v, input int n);
		rxd_out <= v;
		repeat (n) @(posedge mclk_in);
	endtask : hold_line
	// start, data lsb first, one stop of chosen level, then idle
	task automatic send_frame(input logic [8:0] d, input int nb, input int c, input logic s);
		@(posedge mclk_in);
		hold_line(1'b0, c);
		for (int i = 0; i < nb; i++) begin
			hold_line(d[i], c);
		end
		hold_line(s, c);
		hold_line(1'b1, 2 * c);
	endtask : send_frame
	// short low pulse, too short to pass as a start bit
	task automatic pulse(input int n);
		@(posedge mclk_in);
		hold_line(1'b0, n);
		// long enough for a wrongly accepted start to finish a frame
		hold_line(1'b1, 200);
	endtask : pulse
	// park the slave clock at its rest level before sync mode starts
	task automatic park_clock(input logic lvl);
		xclk_out <= lvl;
		repeat (4) @(posedge mclk_in);
	endtask : park_clock
	// slave clock period 2h cycles, lsb first; h of 4 stays under quarter rate
	task automatic clock_byte(input logic [7:0] d, input int h, input logic inv);
		for (int i = 0; i < 8; i++) begin
			@(posedge mclk_in);
			rxd_out <= d[i];
			xclk_out <= !inv;
			repeat (h) @(posedge mclk_in);
			xclk_out <= inv;
			repeat (h - 1) @(posedge mclk_in);
		end
		rxd_out <= 1'b1;
	endtask : clock_byte
endmodule : uart_peer_model

/* verif/test_usart_sync_spi_async_receive.sv */
// testbench: self-checking run of the receive block with a serial peer
`timescale 1ns/1ps
module test_usart_sync_spi_async_receive;
	import usart_rx_pkg::*;
	logic mclk_in = 1'b0;
	logic arst_n_in = 1'b0;
	logic ce_in = 1'b1;
	logic rx_enable_in = 1'b0;
	comm_mode_type comm_mode_in = MODE_ASYNC;
	logic [2:0] char_size_field_in = CHSZ_8;
	logic [1:0] rx_sampling_mode_in = RXM_NORMAL;
	logic [1:0] parity_mode_in = 2'h0;
	logic data_order_bit_in = 1'b0;
	logic clock_phase_bit_in = 1'b0;
	logic pin_invert_enable_in = 1'b0;
	logic transfer_clock_dir_in = 1'b0;
	// integer part one: one sample per clock keeps frames short
	logic [15:0] baud_in = BAUD_RESET;
	logic rd_high_in = 1'b0;
	logic rd_low_in = 1'b0;
	logic rxd_in;
	logic transfer_clock_pin_in;
	logic transfer_clock_pin_out;
	logic transfer_clock_pin_oe_out;
	logic [7:0] rx_data_low_reg_out;
	logic [7:0] rx_data_high_reg_out;
	logic rx_complete_flag_out;
	int failures = 0;
	int checks_done = 0;
	int cycles = 0;
	usart_rx_core usart_rx_core_inst (.mclk_in, .arst_n_in, .ce_in, .rx_enable_in,
		.comm_mode_in, .char_size_field_in, .rx_sampling_mode_in, .parity_mode_in,
		.data_order_bit_in, .clock_phase_bit_in, .pin_invert_enable_in,
		.transfer_clock_dir_in, .baud_in, .rxd_in, .transfer_clock_pin_in,
		.transfer_clock_pin_out, .transfer_clock_pin_oe_out, .rd_high_in, .rd_low_in,
		.rx_data_low_reg_out, .rx_data_high_reg_out, .rx_complete_flag_out);
	uart_peer_model uart_peer_model_inst (.mclk_in(mclk_in), .rxd_out(rxd_in),
		.xclk_out(transfer_clock_pin_in));
	////////////////////////////////////////
	initial begin
		forever #2.5 mclk_in = ~mclk_in;
	end
	// hang guard, well above the few thousand cycles needed
	always @(posedge mclk_in) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			report_and_stop;
		end
	end
	task automatic report_and_stop;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : report_and_stop
	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("Error %s expected %0h seen %0h", nm, exp, got);
		end
	endtask : chk
	// one-cycle read pulse; outputs checked after the popping edge settles
	task automatic rd(input logic h, input logic l);
		@(posedge mclk_in);
		rd_high_in <= h;
		rd_low_in <= l;
		@(posedge mclk_in);
		rd_high_in <= 1'b0;
		rd_low_in <= 1'b0;
		#1;
	endtask : rd
	task automatic send(input logic [8:0] d, input int nb, input int c, input logic s);
		uart_peer_model_inst.send_frame(d, nb, c, s);
		#1;
	endtask : send
	task automatic t_order(input logic [1:0] m, input int c);
		@(posedge mclk_in);
		rx_sampling_mode_in <= m;
		send(9'h0A5, 8, c, 1'b1);
		send(9'h03C, 8, c, 1'b1);
		chk("high", 8'h80, rx_data_high_reg_out);
		chk("low", 8'hA5, rx_data_low_reg_out);
		rd(1'b1, 1'b0);
		chk("low after peek", 8'hA5, rx_data_low_reg_out);
		rd(1'b0, 1'b1);
		chk("low after pop", 8'h3C, rx_data_low_reg_out);
		rd(1'b0, 1'b1);
		chk("flag", 8'h00, {7'h00, rx_complete_flag_out});
	endtask : t_order
	task automatic t_glitch(input logic [1:0] m, input int n);
		@(posedge mclk_in);
		rx_sampling_mode_in <= m;
		uart_peer_model_inst.pulse(n);
		#1;
		chk("flag after pulse", 8'h00, {7'h00, rx_complete_flag_out});
	endtask : t_glitch
	task automatic t_nine_frame_error_flag;
		@(posedge mclk_in);
		rx_sampling_mode_in <= RXM_NORMAL;
		char_size_field_in <= CHSZ_9_LOW_FIRST;
		send(9'h1C3, 9, 16, 1'b1);
		chk("high nine", 8'h81, rx_data_high_reg_out);
		rd(1'b0, 1'b1);
		chk("low nine", 8'hC3, rx_data_low_reg_out);
		chk("high kept", 8'h81, rx_data_high_reg_out);
		rd(1'b1, 1'b0);
		chk("high popped", 8'h00, rx_data_high_reg_out);
		@(posedge mclk_in);
		char_size_field_in <= CHSZ_8;
		send(9'h055, 8, 16, 1'b0);
		chk("high frame_error_flag", 8'h84, rx_data_high_reg_out);
		chk("low frame_error_flag", 8'h55, rx_data_low_reg_out);
		rd(1'b0, 1'b1);
	endtask : t_nine_frame_error_flag
	task automatic t_flush;
		send(9'h011, 8, 16, 1'b1);
		send(9'h022, 8, 16, 1'b1);
		send(9'h033, 8, 16, 1'b1);
		chk("high ovf", 8'hC0, rx_data_high_reg_out);
		rd(1'b1, 1'b0);
		rd(1'b0, 1'b1);
		chk("low next", 8'h22, rx_data_low_reg_out);
		// the held third word still waits at the pop, so overflow stays set
		chk("high next", 8'hC0, rx_data_high_reg_out);
		for (int i = 0; i < 4 && rx_complete_flag_out === 1'b1; i++) begin
			rd(1'b1, 1'b0);
			rd(1'b0, 1'b1);
		end
		chk("flag flushed", 8'h00, {7'h00, rx_complete_flag_out});
	endtask : t_flush
	task automatic t_disable;
		send(9'h0AA, 8, 16, 1'b1);
		fork
			send(9'h0F0, 8, 16, 1'b1);
			begin
				repeat (80) @(posedge mclk_in);
				rx_enable_in <= 1'b0;
				@(posedge mclk_in);
				#1;
				chk("flag off", 8'h00, {7'h00, rx_complete_flag_out});
			end
		join
		@(posedge mclk_in);
		rx_enable_in <= 1'b1;
		repeat (200) @(posedge mclk_in);
		#1;
		chk("partial dropped", 8'h00, {7'h00, rx_complete_flag_out});
	endtask : t_disable
	task automatic t_roles;
		// a framing-error word stands in the buffer while spi is selected
		send(9'h055, 8, 16, 1'b0);
		@(posedge mclk_in);
		comm_mode_in <= MODE_SPI_MASTER;
		pin_invert_enable_in <= 1'b1;
		clock_phase_bit_in <= 1'b1;
		data_order_bit_in <= 1'b1;
		repeat (3) @(posedge mclk_in);
		#1;
		chk("spi errors", 8'h00, rx_data_high_reg_out & 8'h06);
		chk("spi head", 8'h55, rx_data_low_reg_out);
		@(posedge mclk_in);
		rx_enable_in <= 1'b0;
		comm_mode_in <= MODE_SYNC;
		transfer_clock_dir_in <= 1'b1;
		pin_invert_enable_in <= 1'b0;
		clock_phase_bit_in <= 1'b0;
		data_order_bit_in <= 1'b0;
		repeat (3) @(posedge mclk_in);
		#1;
		chk("oe master", 8'h01, {7'h00, transfer_clock_pin_oe_out});
		chk("clock idle", 8'h00, {7'h00, transfer_clock_pin_out});
		// master spi with the line held high runs words off its own clock
		@(posedge mclk_in);
		rx_enable_in <= 1'b1;
		comm_mode_in <= MODE_SPI_MASTER;
		repeat (40) @(posedge mclk_in);
		#1;
		chk("spi word", 8'hFF, rx_data_low_reg_out);
		chk("spi high", 8'h80, rx_data_high_reg_out);
		@(posedge mclk_in);
		rx_enable_in <= 1'b0;
		comm_mode_in <= MODE_SYNC;
		transfer_clock_dir_in <= 1'b0;
		repeat (3) @(posedge mclk_in);
		#1;
		chk("oe slave", 8'h00, {7'h00, transfer_clock_pin_oe_out});
		@(posedge mclk_in);
		comm_mode_in <= MODE_ASYNC;
	endtask : t_roles
	// sync slave: byte clocked in by the peer; a huge baud must not matter
	task automatic t_slave(input logic inv, input logic [7:0] d);
		@(posedge mclk_in);
		rx_enable_in <= 1'b1;
		pin_invert_enable_in <= inv;
		baud_in <= 16'hFFC0;
		uart_peer_model_inst.park_clock(inv);
		comm_mode_in <= MODE_SYNC;
		uart_peer_model_inst.clock_byte(d, 4, inv);
		repeat (4) @(posedge mclk_in);
		#1;
		chk("slave low", d, rx_data_low_reg_out);
		chk("slave high", 8'h80, rx_data_high_reg_out);
		@(posedge mclk_in);
		rx_enable_in <= 1'b0;
		comm_mode_in <= MODE_ASYNC;
		pin_invert_enable_in <= 1'b0;
		baud_in <= BAUD_RESET;
	endtask : t_slave
	////////////////////////////////////////
	// main sequence: reset, then each scenario in turn
	initial begin
		repeat (4) @(posedge mclk_in);
		arst_n_in <= 1'b1;
		rx_enable_in <= 1'b1;
		repeat (2) @(posedge mclk_in);
		#1;
		t_order(RXM_NORMAL, SAMPLES_NORMAL);
		t_order(RXM_DOUBLE, SAMPLES_DOUBLE);
		t_glitch(RXM_NORMAL, 6);
		t_glitch(RXM_DOUBLE, 3);
		t_nine_frame_error_flag;
		t_flush;
		t_disable;
		t_roles;
		t_slave(1'b0, 8'hB4);
		t_slave(1'b1, 8'h4D);
		report_and_stop;
	end
endmodule : test_usart_sync_spi_async_receive
